// >>> fault_protect_pkg.sv
/*
 * shared constants and carriers for the motor driver fault supervisor.
 * assumes a single 250 MHz core clock; detector flags arrive from analog
 * comparators outside the clock domain.
 */
package fault_protect_pkg;

    // -------------------------------------------------------------------
    // timing
    // -------------------------------------------------------------------
    localparam int unsigned CLK_MHZ          = 250;
    localparam int unsigned TEMP_DEADBAND_NS = 2000;  // plain default, not given
    localparam int unsigned CUR_DEADBAND_NS  = 1000;  // plain default, not given
    localparam int unsigned FLT_PULSE_MIN_NS = 156;
    localparam int unsigned FLT_PULSE_MAX_NS = 312;
    // least times round up, never below one cycle
    localparam int unsigned TEMP_DB_CYC = (TEMP_DEADBAND_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned CUR_DB_CYC  = (CUR_DEADBAND_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned PULSE_CYC   = (FLT_PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned PULSE_MAX_CYC = (FLT_PULSE_MAX_NS * CLK_MHZ) / 1000;
    localparam int unsigned CNT_W       = 12;

    // -------------------------------------------------------------------
    // chopping threshold
    // -------------------------------------------------------------------
    localparam int unsigned REF_W    = 12;
    localparam int unsigned REF_GAIN = 5;

    // -------------------------------------------------------------------
    // carriers
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {
        TEMP_OK    = 2'b00,
        TEMP_QUAL  = 2'b01,
        TEMP_SHUT  = 2'b11,
        TEMP_BLIP  = 2'b10
    } temp_state_e;

    typedef struct packed {
        logic temp_raw;
        logic cur_raw_a;
        logic cur_raw_b;
    } detect_s;

    typedef struct packed {
        detect_s            s1;
        detect_s            s2;
        detect_s            s3;
        detect_s            lvl;
        temp_state_e        temp_st;
        logic               temp_shut;
        logic [CNT_W-1:0]   temp_cnt;
        logic [CNT_W-1:0]   cur_cnt;
        logic [CNT_W-1:0]   pulse_cnt;
        logic               cur_latched;
        logic               bridge_en_a;
        logic               bridge_en_b;
        logic               fault_n;
        logic               chop_trip_a;
        logic               chop_trip_b;
    } state_s;

endpackage

// >>> motor_driver_fault_protect_tb.sv
/*
 * self-checking bench for the fault supervisor with the motor model beside it.
 * assumes the package deadbands (500 and 250 cycles) and the 39 cycle blip.
 */
module motor_driver_fault_protect_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct { logic [6:0] val; logic [6:0] mask; int due; } note_s;
    logic        clk_in, rstn_in, over_temp, req_a, req_b;
    logic        sh_a, sh_b, ba, bb, ots, lat, fn, ta, tb, ea, eb;
    logic [11:0] ref_a, ref_b, lvl_a, lvl_b, sen_a, sen_b;
    logic [31:0] seed;
    int          cyc, bad_count, tests_run;
    note_s       q[$];

    motor_fault_protect i_motor_fault_protect (.clk_in(clk_in), .rstn_in(rstn_in),
        .over_temp_in(over_temp), .short_a_in(sh_a), .short_b_in(sh_b),
        .ref_code_a_in(ref_a), .ref_code_b_in(ref_b), .sense_resistor_a_in(sen_a),
        .sense_resistor_b_in(sen_b), .bridge_en_a_out(ba), .bridge_en_b_out(bb),
        .over_temp_shutdown_out(ots), .cur_latched_out(lat), .fault_n_out(fn),
        .chop_trip_a_out(ta), .chop_trip_b_out(tb));
    motor_model i_motor_model (.bridge_en_a_in(ba), .bridge_en_b_in(bb),
        .short_req_a_in(req_a), .short_req_b_in(req_b), .level_a_in(lvl_a),
        .level_b_in(lvl_b), .short_a_out(sh_a), .short_b_out(sh_b),
        .sense_a_out(sen_a), .sense_b_out(sen_b));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic note(input int d, input logic [6:0] v, input logic [6:0] m);
        note_s n;
        n.val = v;
        n.mask = m;
        n.due = cyc + d;
        q.push_back(n);
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic check(input logic [6:0] seen, input logic [6:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // clock, cycle count, watchdog and result monitor
    // ------------------------------------------------------------------
    initial
    begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    always @(posedge clk_in) cyc <= cyc + 1;
    // the whole run needs under 2000 cycles, so 5000 means a hang
    initial
    begin
        #(4 * 5000);
        bad_count++;
        end_sim();
    end
    // outputs are registered, so the falling edge sees them settled
    always @(negedge clk_in)
        while (q.size() > 0 && q[0].due <= cyc)
        begin
            check({ba, bb, ots, lat, fn, ta, tb} & q[0].mask, q[0].val & q[0].mask);
            void'(q.pop_front());
        end

    // ------------------------------------------------------------------
    // stimulus, changed on falling edges only
    // ------------------------------------------------------------------
    initial
    begin
        {rstn_in, over_temp, req_a, req_b} = 4'h0;
        {ref_a, ref_b, lvl_a, lvl_b} = '0;
        {bad_count, tests_run} = '0;
        seed = 32'h0001373B;
        cycles(6);
        rstn_in = 1'b1;
        cycles(2);
        // random references and sense levels; trip one cycle later
        for (int i = 0; i < 24; i++)
        begin
            seed = xs(seed);
            lvl_a = {2'h0, seed[9:0]};
            ref_a = seed[21:10];
            lvl_b = {2'h0, seed[31:22]};
            ref_b = seed[11:0];
            ea = 5 * int'(lvl_a) >= int'(ref_a);
            eb = 5 * int'(lvl_b) >= int'(ref_b);
            note(1, {5'h19, ea, eb}, 7'h7F);
            cycles(1);
        end
        $display("test chop done");
        // a hot burst shorter than the deadband is ignored
        over_temp = 1'b1;
        note(95, 7'h64, 7'h7C);
        cycles(100);
        over_temp = 1'b0;
        cycles(20);
        // a lasting overheat stops both bridges, then recovers with a blip
        over_temp = 1'b1;
        note(520, 7'h10, 7'h7C);
        note(595, 7'h10, 7'h7C);
        cycles(600);
        over_temp = 1'b0;
        note(10, 7'h60, 7'h7C);
        note(40, 7'h60, 7'h7C);
        note(60, 7'h64, 7'h7C);
        cycles(70);
        $display("test thermal done");
        // a switching spike shorter than the deadband is masked
        req_a = 1'b1;
        note(195, 7'h64, 7'h7C);
        cycles(200);
        req_a = 1'b0;
        cycles(10);
        // a lasting short on one channel latches both bridges off
        req_b = 1'b1;
        note(260, 7'h08, 7'h7C);
        cycles(300);
        req_b = 1'b0;
        note(100, 7'h08, 7'h7C);
        cycles(110);
        // only a full reset clears the latch
        rstn_in = 1'b0;
        note(2, 7'h64, 7'h7C);
        cycles(3);
        rstn_in = 1'b1;
        note(5, 7'h64, 7'h7C);
        cycles(8);
        $display("test overcurrent done");
        end_sim();
    end
endmodule

// >>> motor_fault_protect.sv
/*
 * fault supervisor for a two channel stepping motor bridge driver: filters
 * the over-temperature and over-current detector flags, gates the bridges
 * and drives the active-low fault output; also compares the sense voltage
 * against the reference divided by the fixed gain.
 * assumes detector flags and comparator codes are asynchronous to clk_in,
 * and rstn_in is the power-on or equivalent full reset.
 */
// What this block does
// - chop threshold equals reference divided by five
// - overheating switches off both bridges
// - overheat acts only after deadband persists
// - overheat shutdown recovers automatically when cleared
// - early clear gives short low fault pulse
// - output shorts count as over-current faults
// - over-current qualified through switching-spike deadband
// - over-current switches off both bridges
// - over-current shutdown latches, state held
module motor_fault_protect (
    input  wire logic                                  clk_in,
    input  wire logic                                  rstn_in,
    input  wire logic                                  over_temp_in,
    input  wire logic                                  short_a_in,
    input  wire logic                                  short_b_in,
    input  wire logic [fault_protect_pkg::REF_W-1:0]   ref_code_a_in,
    input  wire logic [fault_protect_pkg::REF_W-1:0]   ref_code_b_in,
    input  wire logic [fault_protect_pkg::REF_W-1:0]   sense_resistor_a_in,
    input  wire logic [fault_protect_pkg::REF_W-1:0]   sense_resistor_b_in,
    output logic                                       bridge_en_a_out,
    output logic                                       bridge_en_b_out,
    output logic                                       over_temp_shutdown_out,
    output logic                                       cur_latched_out,
    output logic                                       fault_n_out,
    output logic                                       chop_trip_a_out,
    output logic                                       chop_trip_b_out
);

    fault_protect_pkg::state_s st_r;
    fault_protect_pkg::state_s st_nxt;

    // -------------------------------------------------------------------
    // filtered detector levels
    // -------------------------------------------------------------------
    // a change counts once the second and third stage agree; until then the
    // last agreed level stands, so one unsettled stage never toggles it
    fault_protect_pkg::detect_s lvl;
    logic                       temp_hot;
    logic                       cur_hit;
    assign lvl.temp_raw  = (st_r.s2.temp_raw == st_r.s3.temp_raw) ? st_r.s2.temp_raw
                                                                   : st_r.lvl.temp_raw;
    assign lvl.cur_raw_a = (st_r.s2.cur_raw_a == st_r.s3.cur_raw_a) ? st_r.s2.cur_raw_a
                                                                     : st_r.lvl.cur_raw_a;
    assign lvl.cur_raw_b = (st_r.s2.cur_raw_b == st_r.s3.cur_raw_b) ? st_r.s2.cur_raw_b
                                                                     : st_r.lvl.cur_raw_b;
    assign temp_hot = lvl.temp_raw;
    assign cur_hit  = lvl.cur_raw_a | lvl.cur_raw_b;

    // -------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.s1.temp_raw  = over_temp_in;
        st_nxt.s1.cur_raw_a = short_a_in;
        st_nxt.s1.cur_raw_b = short_b_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.lvl = lvl;

        // over-current: counter restarts on any gap, so spikes never trip
        if (st_r.cur_latched)
        begin
            st_nxt.cur_cnt = st_r.cur_cnt;
        end
        else if (cur_hit)
        begin
            if (st_r.cur_cnt == fault_protect_pkg::CNT_W'(fault_protect_pkg::CUR_DB_CYC - 1))
            begin
                st_nxt.cur_latched = 1'b1;
            end
            else
            begin
                st_nxt.cur_cnt = st_r.cur_cnt + 1'b1;
            end
        end
        else
        begin
            st_nxt.cur_cnt = '0;
        end

        // over-temperature state machine
        unique case (st_r.temp_st)
            fault_protect_pkg::TEMP_OK:
            begin
                st_nxt.temp_cnt = '0;
                if (temp_hot)
                begin
                    st_nxt.temp_st = fault_protect_pkg::TEMP_QUAL;
                end
            end
            fault_protect_pkg::TEMP_QUAL:
            begin
                if (!temp_hot)
                begin
                    st_nxt.temp_st = fault_protect_pkg::TEMP_OK;
                end
                else if (st_r.temp_cnt ==
                         fault_protect_pkg::CNT_W'(fault_protect_pkg::TEMP_DB_CYC - 1))
                begin
                    st_nxt.temp_st = fault_protect_pkg::TEMP_SHUT;
                end
                else
                begin
                    st_nxt.temp_cnt = st_r.temp_cnt + 1'b1;
                end
            end
            fault_protect_pkg::TEMP_SHUT:
            begin
                // clearing at any time while shut: resume and blip fault
                if (!temp_hot)
                begin
                    st_nxt.temp_st   = fault_protect_pkg::TEMP_BLIP;
                    st_nxt.pulse_cnt = '0;
                end
            end
            fault_protect_pkg::TEMP_BLIP:
            begin
                if (temp_hot)
                begin
                    st_nxt.temp_st  = fault_protect_pkg::TEMP_QUAL;
                    st_nxt.temp_cnt = '0;
                end
                else if (st_r.pulse_cnt ==
                         fault_protect_pkg::CNT_W'(fault_protect_pkg::PULSE_CYC - 1))
                begin
                    st_nxt.temp_st = fault_protect_pkg::TEMP_OK;
                end
                else
                begin
                    st_nxt.pulse_cnt = st_r.pulse_cnt + 1'b1;
                end
            end
        endcase

        // shutdown flag kept in its own flop so the output needs no decode
        st_nxt.temp_shut = (st_nxt.temp_st == fault_protect_pkg::TEMP_SHUT);
        // both bridges go off for either fault, never just one channel
        st_nxt.bridge_en_a = !(st_nxt.cur_latched || st_nxt.temp_shut);
        st_nxt.bridge_en_b = st_nxt.bridge_en_a;
        // fault low while shut, and for the short blip after any clear from shutdown
        st_nxt.fault_n = st_nxt.bridge_en_a &&
                         st_nxt.temp_st != fault_protect_pkg::TEMP_BLIP;

        // sense >= ref/5, written as 5*sense >= ref to avoid a divider
        st_nxt.chop_trip_a = ({3'h0, sense_resistor_a_in} * 15'(fault_protect_pkg::REF_GAIN))
                             >= {3'h0, ref_code_a_in};
        st_nxt.chop_trip_b = ({3'h0, sense_resistor_b_in} * 15'(fault_protect_pkg::REF_GAIN))
                             >= {3'h0, ref_code_b_in};
    end

    // -------------------------------------------------------------------
    // state register
    // -------------------------------------------------------------------
    // only this reset releases the over-current latch
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            st_r             <= '0;
            st_r.bridge_en_a <= 1'b1;
            st_r.bridge_en_b <= 1'b1;
            st_r.fault_n     <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign bridge_en_a_out        = st_r.bridge_en_a;
    assign bridge_en_b_out        = st_r.bridge_en_b;
    assign over_temp_shutdown_out = st_r.temp_shut;
    assign cur_latched_out        = st_r.cur_latched;
    assign fault_n_out            = st_r.fault_n;
    assign chop_trip_a_out        = st_r.chop_trip_a;
    assign chop_trip_b_out        = st_r.chop_trip_b;

    // -------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------
    sequence s_shut;
        st_r.temp_st == fault_protect_pkg::TEMP_SHUT;
    endsequence
    sequence s_clear;
        !temp_hot;
    endsequence

    a_temp_shut_off: assert property (@(posedge clk_in) disable iff (!rstn_in)
        s_shut |-> !bridge_en_a_out && !bridge_en_b_out)
        else $error("bridges on during thermal shutdown");
    a_temp_deadband: assert property (@(posedge clk_in) disable iff (!rstn_in)
        $rose(st_r.temp_st == fault_protect_pkg::TEMP_SHUT) |->
        st_r.temp_cnt == fault_protect_pkg::CNT_W'(fault_protect_pkg::TEMP_DB_CYC - 1))
        else $error("thermal shutdown before deadband");
    a_temp_recover: assert property (@(posedge clk_in) disable iff (!rstn_in)
        s_shut ##0 s_clear |=> bridge_en_a_out || cur_latched_out)
        else $error("no recovery after thermal clear");
    a_blip_low: assert property (@(posedge clk_in) disable iff (!rstn_in)
        s_shut ##0 s_clear ##1 (!temp_hot)[*2] |-> !fault_n_out ##1 !fault_n_out)
        else $error("fault pulse missing");
    a_blip_len: assert property (@(posedge clk_in) disable iff (!rstn_in)
        $fell(st_r.temp_st == fault_protect_pkg::TEMP_BLIP)
        && st_r.temp_st == fault_protect_pkg::TEMP_OK
        |-> $past(st_r.pulse_cnt) == fault_protect_pkg::CNT_W'(fault_protect_pkg::PULSE_CYC - 1))
        else $error("fault pulse too short");
    a_blip_max: assert property (@(posedge clk_in) disable iff (!rstn_in)
        st_r.temp_st == fault_protect_pkg::TEMP_BLIP
        |-> st_r.pulse_cnt < fault_protect_pkg::CNT_W'(fault_protect_pkg::PULSE_MAX_CYC))
        else $error("fault pulse too long");
    a_cur_latch: assert property (@(posedge clk_in) disable iff (!rstn_in)
        cur_latched_out |=> cur_latched_out && !bridge_en_b_out)
        else $error("over-current latch released");
    a_cur_both: assert property (@(posedge clk_in) disable iff (!rstn_in)
        $rose(cur_latched_out) |-> !bridge_en_a_out && !bridge_en_b_out)
        else $error("only one bridge off");
    a_cur_deadband: assert property (@(posedge clk_in) disable iff (!rstn_in)
        $rose(cur_latched_out) |-> $past(cur_hit)
        && $past(st_r.cur_cnt) == fault_protect_pkg::CNT_W'(fault_protect_pkg::CUR_DB_CYC - 1))
        else $error("over-current latched without deadband");
    a_spike_mask: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !cur_hit && !cur_latched_out |=> st_r.cur_cnt == '0)
        else $error("spike count not restarted");
    a_short_trips: assert property (@(posedge clk_in) disable iff (!rstn_in)
        cur_hit && st_r.cur_cnt == fault_protect_pkg::CNT_W'(fault_protect_pkg::CUR_DB_CYC - 1)
        |=> cur_latched_out && !bridge_en_a_out)
        else $error("persistent short did not trip");
    a_reset_clear: assert property (@(posedge clk_in)
        $rose(rstn_in) |-> !cur_latched_out)
        else $error("latch survived reset");
    a_chop_gain: assert property (@(posedge clk_in) disable iff (!rstn_in)
        $past(rstn_in) |->
        chop_trip_a_out == ($past(sense_resistor_a_in) * 5 >= $past(ref_code_a_in)))
        else $error("chop compare wrong");
    a_chop_gain_b: assert property (@(posedge clk_in) disable iff (!rstn_in)
        $past(rstn_in) |->
        chop_trip_b_out == ($past(sense_resistor_b_in) * 5 >= $past(ref_code_b_in)))
        else $error("chop compare wrong on channel b");

endmodule

// >>> motor_model.sv
/*
 * far-side model: the motor windings and shorts seen behind the two bridges.
 * assumes the bench chooses the wanted shorts and winding current levels.
 */
module motor_model (
    input  wire logic                                bridge_en_a_in,
    input  wire logic                                bridge_en_b_in,
    input  wire logic                                short_req_a_in,
    input  wire logic                                short_req_b_in,
    input  wire logic [fault_protect_pkg::REF_W-1:0] level_a_in,
    input  wire logic [fault_protect_pkg::REF_W-1:0] level_b_in,
    output logic                                     short_a_out,
    output logic                                     short_b_out,
    output logic [fault_protect_pkg::REF_W-1:0]      sense_a_out,
    output logic [fault_protect_pkg::REF_W-1:0]      sense_b_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // a bridge that is off carries no current, so the short flag and sense drop
    assign short_a_out = short_req_a_in & bridge_en_a_in;
    assign short_b_out = short_req_b_in & bridge_en_b_in;
    assign sense_a_out = bridge_en_a_in ? level_a_in : '0;
    assign sense_b_out = bridge_en_b_in ? level_b_in : '0;
endmodule
